// [core/hpsg_pkg.sv]
package hpsg_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFF_PIN_CFG = 8'h00;
    localparam logic [7:0] OFF_MEASURE = 8'h04;
    localparam logic [7:0] OFF_PULL = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_MODE = 8'h18;
    localparam logic [7:0] OFF_WAKE_SRC = 8'h1c;

    // Pin configuration codes.
    localparam logic [2:0] CFG_FAIL = 3'h0;
    localparam logic [2:0] CFG_HS_CYCLIC = 3'h3;
    localparam logic [2:0] CFG_OFF = 3'h4;
    localparam logic [2:0] CFG_WAKE = 3'h5;
    localparam logic [2:0] CFG_LS = 3'h6;
    localparam logic [2:0] CFG_HS = 3'h7;

    // Field positions.
    localparam int PULL_DOWN_BIT = 0;
    localparam int PULL_UP_BIT = 1;
    localparam int IRQ_CMD_ERR = 0;
    localparam int IRQ_WAKE = 1;
    localparam int IRQ_OVERCURRENT = 2;
    localparam int IRQ_OPEN_LOAD = 3;
    localparam int WSRC_PIN = 0;
    localparam int WSRC_OTHER = 1;

    // Reset values.
    localparam logic [2:0] RST_PIN_CFG = CFG_FAIL;
    localparam logic [1:0] RST_PULL = 2'h0;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;
    localparam logic [1:0] RST_WAKE_SRC = 2'h1;

    // Timing, counted on the 200 MHz internal oscillator.
    localparam int CLK_PERIOD_NS = 5;
    localparam int WAKE_FILT_NS = 16000;
    localparam int WAKE_BLANK_NS = 30000;
    localparam int OC_FILT_NS = 26000;
    localparam int OL_FILT_NS = 64000;
    localparam int CNT_W = 14;
    localparam logic [CNT_W-1:0] WAKE_FILT_CYC =
        CNT_W'(WAKE_FILT_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WAKE_BLANK_CYC =
        CNT_W'(WAKE_BLANK_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] OC_FILT_CYC =
        CNT_W'(OC_FILT_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] OL_FILT_CYC =
        CNT_W'(OL_FILT_NS / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_RESTART = 3'b100
    } hpsg_mode_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } hpsg_bus_type;

    typedef struct packed {
        logic fail_request;
        logic low_current;
        logic overcurrent;
        logic wake_pin;
    } hpsg_sense_type;

endpackage

// [core/hpsg_qual_filter.sv]
`timescale 1ns/1ps
module hpsg_qual_filter
    import hpsg_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Condition and length.
    input wire logic cond,
    input wire logic [CNT_W-1:0] term,
    // Result.
    output logic hit
);

    logic [CNT_W-1:0] count;

    // The count starts over whenever the condition drops.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (!cond) begin
            count <= '0;
        end else if (count != term) begin
            count <= count + 1'b1;
        end
    end

    // One pulse when the terminal count is reached.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hit <= 1'b0;
        end else begin
            hit <= cond && (count == term - 1'b1);
        end
    end

endmodule

// [core/hpsg_guard.sv]
`timescale 1ns/1ps
// How it works
// - Measurement on turns off pin pulls and blocks the pin's wake signal.
// - Pull settings written during measurement are stored but not applied.
// - Pin configuration writes are rejected while measurement is enabled.
// - Measurement enable is refused with error when pin is fail output.
// - During measurement wake detection, wake status and level stay frozen.
// - Sleep during measurement with pin as only wake source gives error and restart mode.
// - Wake level change accepted only after 16 us of stable level.
// - Wake events ignored for 30 us after wake input is enabled.
// - Overcurrent declared after 26 us persistence in either switch mode.
// - Open load declared after 64 us persistence in high-side mode.
// - All filter and blanking times are counted on the oscillator.
// - During measurement fail output and switch functions are unavailable.
// - Overcurrent shutdown turns the switch off and sets config to off.
module hpsg_guard
    import hpsg_pkg::*;
#(
    parameter logic [CNT_W-1:0] BLANK_CYC = WAKE_BLANK_CYC,
    parameter logic [CNT_W-1:0] OC_CYC = OC_FILT_CYC,
    parameter logic [CNT_W-1:0] OL_CYC = OL_FILT_CYC
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Bus slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pin sense inputs, asynchronous.
    input wire hpsg_sense_type sense,
    // Pin controls.
    output logic pull_up_en,
    output logic pull_down_en,
    output logic switch_hs_on,
    output logic switch_ls_on,
    output logic fail_output_on,
    output logic measure_route_en,
    // Device state and interrupt.
    output hpsg_mode_type device_mode,
    output logic irq
);

    hpsg_bus_type ap;
    hpsg_sense_type sense_meta;
    hpsg_sense_type sense_s;
    logic [2:0] pin_cfg;
    logic hv_measure_enable;
    logic [1:0] wake_pull_config;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [1:0] wake_src_en;
    logic wake_level_status;
    logic blank_done;
    logic wake_hit;
    logic blank_hit;
    logic oc_hit;
    logic ol_hit;
    logic wr;
    logic wr_cfg;
    logic wr_meas;
    logic wr_mode;
    logic wake_act;
    logic switch_cfg;
    logic sleep_refuse;
    logic wake_evt;
    logic cmd_err;
    logic [3:0] next_irq_stat;

    function automatic logic [31:0] read_reg(input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0;
        unique case (a)
            OFF_PIN_CFG: d[2:0] = pin_cfg;
            OFF_MEASURE: d[0] = hv_measure_enable;
            OFF_PULL: d[1:0] = wake_pull_config;
            OFF_STATUS: d[4:0] = {blank_done, device_mode, wake_level_status};
            OFF_IRQ_STAT: d[3:0] = irq_stat;
            OFF_IRQ_MASK: d[3:0] = irq_mask;
            OFF_MODE: d[0] = (device_mode == MODE_SLEEP);
            OFF_WAKE_SRC: d[1:0] = wake_src_en;
            default: d = 32'h0;
        endcase
        return d;
    endfunction

    // Two-stage synchroniser for all pin inputs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sense_meta <= '0;
            sense_s <= '0;
        end else begin
            sense_meta <= sense;
            sense_s <= sense_meta;
        end
    end

    // Address phase capture; the slave never inserts wait states.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap <= '0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            ap.valid <= hsel && htrans[1] && hready;
            ap.write <= hwrite;
            ap.addr <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hsel && htrans[1] && hready && !hwrite) begin
                hrdata <= read_reg(haddr[7:0]);
            end
        end
    end

    assign wr = ap.valid && ap.write;
    assign wr_cfg = wr && (ap.addr == OFF_PIN_CFG);
    assign wr_meas = wr && (ap.addr == OFF_MEASURE);
    assign wr_mode = wr && (ap.addr == OFF_MODE);
    assign wake_act = (pin_cfg == CFG_WAKE) && !hv_measure_enable;
    assign switch_cfg = (pin_cfg == CFG_LS) || (pin_cfg == CFG_HS)
        || (pin_cfg == CFG_HS_CYCLIC);
    assign sleep_refuse = wr_mode && hwdata[0] && hv_measure_enable
        && (wake_src_en == 2'h1);
    assign wake_evt = wake_hit && blank_done && wake_act;
    assign cmd_err = (wr_cfg && hv_measure_enable
                      && (hwdata[2:0] != CFG_OFF))
        || (wr_meas && hwdata[0] && !hv_measure_enable
            && (pin_cfg == CFG_FAIL))
        || sleep_refuse;

    // Pin configuration register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_cfg <= RST_PIN_CFG;
        end else if (oc_hit) begin
            pin_cfg <= CFG_OFF;
        end else if (wr_cfg && !hv_measure_enable) begin
            pin_cfg <= hwdata[2:0];
        end
    end

    // Measurement enable register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hv_measure_enable <= 1'b0;
        end else if (wr_meas) begin
            if (!hwdata[0] || pin_cfg != CFG_FAIL) begin
                hv_measure_enable <= hwdata[0];
            end
        end
    end

    // Pull, mask and wake source registers are plain storage.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_pull_config <= RST_PULL;
            irq_mask <= RST_IRQ_MASK;
            wake_src_en <= RST_WAKE_SRC;
        end else if (wr) begin
            unique case (ap.addr)
                OFF_PULL: wake_pull_config <= hwdata[1:0];
                OFF_IRQ_MASK: irq_mask <= hwdata[3:0];
                OFF_WAKE_SRC: wake_src_en <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    // Device mode: sleep requests, refused entry and wake exit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            device_mode <= MODE_NORMAL;
        end else begin
            unique case (device_mode)
                MODE_NORMAL: begin
                    if (sleep_refuse) begin
                        device_mode <= MODE_RESTART;
                    end else if (wr_mode && hwdata[0]) begin
                        device_mode <= MODE_SLEEP;
                    end
                end
                MODE_SLEEP: begin
                    if (wake_evt && wake_src_en[WSRC_PIN]) begin
                        device_mode <= MODE_NORMAL;
                    end else if (wr_mode && !hwdata[0]) begin
                        device_mode <= MODE_NORMAL;
                    end
                end
                MODE_RESTART: begin
                    if (wr_mode && !hwdata[0]) begin
                        device_mode <= MODE_NORMAL;
                    end
                end
                default: device_mode <= MODE_RESTART;
            endcase
        end
    end

    // Wake level filter and activation blanking.
    hpsg_qual_filter u_wake_filt (
        .hclk(hclk),
        .hresetn(hresetn),
        .cond(wake_act && (sense_s.wake_pin != wake_level_status)),
        .term(WAKE_FILT_CYC),
        .hit(wake_hit)
    );

    hpsg_qual_filter u_blank (
        .hclk(hclk),
        .hresetn(hresetn),
        .cond(wake_act),
        .term(BLANK_CYC),
        .hit(blank_hit)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blank_done <= 1'b0;
            wake_level_status <= 1'b0;
        end else begin
            if (!wake_act) begin
                blank_done <= 1'b0;
            end else if (blank_hit) begin
                blank_done <= 1'b1;
            end
            if (wake_hit && wake_act) begin
                wake_level_status <= ~wake_level_status;
            end
        end
    end

    // Overcurrent and open-load filters on the switch.
    hpsg_qual_filter u_oc_filt (
        .hclk(hclk),
        .hresetn(hresetn),
        .cond((switch_hs_on || switch_ls_on) && sense_s.overcurrent),
        .term(OC_CYC),
        .hit(oc_hit)
    );

    hpsg_qual_filter u_ol_filt (
        .hclk(hclk),
        .hresetn(hresetn),
        .cond(switch_hs_on && (pin_cfg == CFG_HS) && sense_s.low_current),
        .term(OL_CYC),
        .hit(ol_hit)
    );

    // Sticky event status; a new event wins over a write-one clear.
    always_comb begin
        next_irq_stat = irq_stat;
        if (wr && ap.addr == OFF_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~hwdata[3:0];
        end
        next_irq_stat[IRQ_CMD_ERR] = next_irq_stat[IRQ_CMD_ERR] | cmd_err;
        next_irq_stat[IRQ_WAKE] = next_irq_stat[IRQ_WAKE] | wake_evt;
        next_irq_stat[IRQ_OVERCURRENT] =
            next_irq_stat[IRQ_OVERCURRENT] | oc_hit;
        next_irq_stat[IRQ_OPEN_LOAD] = next_irq_stat[IRQ_OPEN_LOAD] | ol_hit;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= 4'h0;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
        end
    end

    // Pin drive outputs.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pull_up_en <= 1'b0;
            pull_down_en <= 1'b0;
            switch_hs_on <= 1'b0;
            switch_ls_on <= 1'b0;
            fail_output_on <= 1'b0;
            measure_route_en <= 1'b0;
        end else begin
            pull_up_en <= !hv_measure_enable
                && wake_pull_config[PULL_UP_BIT];
            pull_down_en <= !hv_measure_enable
                && wake_pull_config[PULL_DOWN_BIT];
            switch_hs_on <= switch_cfg && (pin_cfg != CFG_LS) && !oc_hit
                && !hv_measure_enable && device_mode != MODE_RESTART;
            switch_ls_on <= (pin_cfg == CFG_LS) && !oc_hit
                && !hv_measure_enable && device_mode != MODE_RESTART;
            fail_output_on <= (pin_cfg == CFG_FAIL) && !hv_measure_enable
                && sense_s.fail_request;
            measure_route_en <= hv_measure_enable;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_meas_pulls_off: assert property (
        hv_measure_enable && $past(hv_measure_enable)
        |-> !pull_up_en && !pull_down_en)
        else $error("pulls active during measurement");

    a_pull_not_applied: assert property (
        hv_measure_enable && wr && ap.addr == OFF_PULL
        |=> !pull_up_en && !pull_down_en)
        else $error("pull write applied during measurement");

    a_cfg_locked: assert property (
        hv_measure_enable |=> $stable(pin_cfg))
        else $error("pin configuration changed during measurement");

    a_meas_refused: assert property (
        wr_meas && hwdata[0] && !hv_measure_enable && pin_cfg == CFG_FAIL
        |=> !hv_measure_enable && irq_stat[IRQ_CMD_ERR])
        else $error("measurement enabled over fail output");

    a_wake_frozen: assert property (
        hv_measure_enable |=> $stable(wake_level_status)
        && !$rose(irq_stat[IRQ_WAKE]))
        else $error("wake status updated during measurement");

    a_sleep_restart: assert property (
        device_mode == MODE_NORMAL && sleep_refuse
        |=> device_mode == MODE_RESTART && irq_stat[IRQ_CMD_ERR])
        else $error("refused sleep did not enter restart");

    a_blank_hold: assert property (
        !blank_done |=> !$rose(irq_stat[IRQ_WAKE]))
        else $error("wake event accepted during blanking");

    a_oc_shutdown: assert property (
        oc_hit |=> pin_cfg == CFG_OFF && !switch_hs_on && !switch_ls_on
        && irq_stat[IRQ_OVERCURRENT])
        else $error("overcurrent did not shut switch down");

    a_fail_blocked: assert property (
        hv_measure_enable |=> !fail_output_on && !switch_hs_on
        && !switch_ls_on)
        else $error("pin function active during measurement");

endmodule

// [dv/hpsg_pin_env.sv]
`timescale 1ns/1ps
module hpsg_pin_env
    import hpsg_pkg::*;
(
    // Switch state at the pin.
    input wire logic switch_hs_on,
    input wire logic switch_ls_on,
    // Load conditions chosen by the bench.
    input wire logic short_on,
    input wire logic open_on,
    input wire logic wake_level,
    input wire logic fail_req,
    // Comparator levels.
    output hpsg_sense_type sense
);
    // A short draws current only while a switch conducts, and a missing
    // load shows only on a conducting high-side switch.
    assign sense = {fail_req, open_on & switch_hs_on,
        short_on & (switch_hs_on | switch_ls_on), wake_level};
endmodule

// [dv/test_hv_pin_sense_guard.sv]
`timescale 1ns/1ps
module test_hv_pin_sense_guard
    import hpsg_pkg::*;
;
    localparam logic [CNT_W-1:0] BLK = 14'd20;
    localparam logic [CNT_W-1:0] OCC = 14'd15;
    localparam logic [CNT_W-1:0] OLC = 14'd30;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic pull_up_en, pull_down_en, switch_hs_on, switch_ls_on;
    logic fail_output_on, measure_route_en;
    logic short_on, open_on, wake_level, fail_req;
    hpsg_mode_type device_mode;
    hpsg_sense_type sense;
    logic [2:0] cfgs [3];
    int err_total;
    int checks;

    hpsg_guard #(.BLANK_CYC(BLK), .OC_CYC(OCC), .OL_CYC(OLC)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sense(sense), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .switch_hs_on(switch_hs_on),
        .switch_ls_on(switch_ls_on), .fail_output_on(fail_output_on),
        .measure_route_en(measure_route_en), .device_mode(device_mode),
        .irq(irq));

    hpsg_pin_env env (.switch_hs_on(switch_hs_on),
        .switch_ls_on(switch_ls_on), .short_on(short_on),
        .open_on(open_on), .wake_level(wake_level), .fail_req(fail_req),
        .sense(sense));

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen,
            input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One single transfer; waits for hready in both phases.
    task automatic xfer(input logic wr_en, input logic [7:0] a,
            input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr_en;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk("hresp", 32'(hresp), 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a,
            input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    task automatic settle();
        repeat (3) @(negedge hclk);
    endtask

    task automatic final_report();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge hclk);
        err_total++;
        final_report();
    end

    initial begin
        err_total = 0;
        checks = 0;
        cfgs = '{CFG_LS, CFG_HS, CFG_HS_CYCLIC};
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        short_on = 1'b0;
        open_on = 1'b0;
        wake_level = 1'b0;
        fail_req = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        chk("mode", 32'(device_mode), 32'(MODE_NORMAL));
        rdchk("pin_cfg", OFF_PIN_CFG, 32'(RST_PIN_CFG));
        rdchk("measure", OFF_MEASURE, 32'h0);
        rdchk("pull", OFF_PULL, 32'(RST_PULL));
        rdchk("irq_stat", OFF_IRQ_STAT, 32'h0);
        rdchk("irq_mask", OFF_IRQ_MASK, 32'(RST_IRQ_MASK));
        rdchk("wake_src", OFF_WAKE_SRC, 32'(RST_WAKE_SRC));
        wr(8'h20, 32'hffff_ffff);
        rdchk("unmapped", 8'h20, 32'h0);
        $display("test reset done");

        wr(OFF_IRQ_MASK, 32'h1);
        fail_req <= 1'b1;
        wr(OFF_MEASURE, 32'h1);
        settle();
        rdchk("measure", OFF_MEASURE, 32'h0);
        rdchk("irq_stat", OFF_IRQ_STAT, 32'h1);
        chk("irq", 32'(irq), 32'h1);
        chk("route", 32'(measure_route_en), 32'h0);
        chk("fail_out", 32'(fail_output_on), 32'h1);
        wr(OFF_IRQ_STAT, 32'h1);
        fail_req <= 1'b0;
        settle();
        chk("irq", 32'(irq), 32'h0);
        wr(OFF_PIN_CFG, 32'(CFG_OFF));
        wr(OFF_MEASURE, 32'h1);
        rdchk("measure", OFF_MEASURE, 32'h1);
        wr(OFF_MEASURE, 32'h0);
        $display("test refused enable done");

        wr(OFF_PIN_CFG, 32'(CFG_WAKE));
        wr(OFF_PULL, 32'h2);
        settle();
        chk("pull_up", 32'(pull_up_en), 32'h1);
        // The pin stays a wake input so that the gating has work to do.
        wr(OFF_MEASURE, 32'h1);
        settle();
        chk("route", 32'(measure_route_en), 32'h1);
        chk("pull_up", 32'(pull_up_en), 32'h0);
        wr(OFF_PULL, 32'h1);
        settle();
        chk("pull_down", 32'(pull_down_en), 32'h0);
        rdchk("pull", OFF_PULL, 32'h1);
        wr(OFF_PIN_CFG, 32'(CFG_HS));
        settle();
        rdchk("pin_cfg", OFF_PIN_CFG, 32'(CFG_WAKE));
        rdchk("irq_stat", OFF_IRQ_STAT, 32'h1);
        chk("switch_hs", 32'(switch_hs_on), 32'h0);
        wr(OFF_IRQ_STAT, 32'h1);
        wake_level <= 1'b1;
        repeat (3400) @(posedge hclk);
        xfer(1'b0, OFF_STATUS, 32'h0);
        chk("wake level", 32'(rd[0]), 32'h0);
        xfer(1'b0, OFF_IRQ_STAT, 32'h0);
        chk("wake event", 32'(rd[1]), 32'h0);
        wake_level <= 1'b0;
        wr(OFF_WAKE_SRC, 32'h1);
        wr(OFF_MODE, 32'h1);
        settle();
        chk("mode", 32'(device_mode), 32'(MODE_RESTART));
        rdchk("irq_stat", OFF_IRQ_STAT, 32'h1);
        wr(OFF_IRQ_STAT, 32'h1);
        wr(OFF_MODE, 32'h0);
        wr(OFF_WAKE_SRC, 32'h3);
        wr(OFF_MODE, 32'h1);
        settle();
        chk("mode", 32'(device_mode), 32'(MODE_SLEEP));
        wr(OFF_MODE, 32'h0);
        wr(OFF_MEASURE, 32'h0);
        settle();
        chk("mode", 32'(device_mode), 32'(MODE_NORMAL));
        chk("route", 32'(measure_route_en), 32'h0);
        $display("test measurement guard done");

        wr(OFF_PIN_CFG, 32'(CFG_WAKE));
        settle();
        chk("pull_down", 32'(pull_down_en), 32'h1);
        wr(OFF_MODE, 32'h1);
        repeat (40) @(posedge hclk);
        wake_level <= 1'b1;
        repeat (3000) @(posedge hclk);
        wake_level <= 1'b0;
        repeat (100) @(posedge hclk);
        wake_level <= 1'b1;
        repeat (3150) @(posedge hclk);
        xfer(1'b0, OFF_STATUS, 32'h0);
        chk("wake level", 32'(rd[0]), 32'h0);
        chk("mode", 32'(device_mode), 32'(MODE_SLEEP));
        repeat (100) @(posedge hclk);
        xfer(1'b0, OFF_STATUS, 32'h0);
        chk("wake level", 32'(rd[0]), 32'h1);
        xfer(1'b0, OFF_IRQ_STAT, 32'h0);
        chk("wake event", 32'(rd[1]), 32'h1);
        chk("mode", 32'(device_mode), 32'(MODE_NORMAL));
        wake_level <= 1'b0;
        wr(OFF_IRQ_STAT, 32'hf);
        $display("test wake filter done");

        for (int i = 0; i < 3; i++) begin
            wr(OFF_PIN_CFG, 32'(cfgs[i]));
            short_on <= 1'b1;
            repeat (10) @(posedge hclk);
            short_on <= 1'b0;
            repeat (30) @(negedge hclk);
            chk("switch", 32'(i == 0 ? switch_ls_on : switch_hs_on),
                32'h1);
            @(posedge hclk);
            short_on <= 1'b1;
            repeat (10) @(negedge hclk);
            chk("switch", 32'(switch_ls_on | switch_hs_on), 32'h1);
            repeat (20) @(negedge hclk);
            chk("switch", 32'(switch_ls_on | switch_hs_on), 32'h0);
            rdchk("pin_cfg", OFF_PIN_CFG, 32'(CFG_OFF));
            short_on <= 1'b0;
            xfer(1'b0, OFF_IRQ_STAT, 32'h0);
            chk("overcurrent", 32'(rd[2]), 32'h1);
            wr(OFF_IRQ_STAT, 32'hf);
        end
        $display("test overcurrent done");

        wr(OFF_PIN_CFG, 32'(CFG_HS));
        open_on <= 1'b1;
        repeat (20) @(posedge hclk);
        xfer(1'b0, OFF_IRQ_STAT, 32'h0);
        chk("open load", 32'(rd[3]), 32'h0);
        repeat (20) @(posedge hclk);
        xfer(1'b0, OFF_IRQ_STAT, 32'h0);
        chk("open load", 32'(rd[3]), 32'h1);
        chk("switch_hs", 32'(switch_hs_on), 32'h1);
        open_on <= 1'b0;
        $display("test open load done");
        final_report();
    end
endmodule
